// ---- common/fdi_cfg.svh ----
// Constants for the fieldbus slave diagnostic and indicator block.
// Assumes a 125 MHz system clock and an APB register bus.
// Functional notes
// RL1: drive red fault and green state lamps
// RL2: flicker both lamps after power-up first
// RL3: node address 3 to 99, else green dark
// RL4: fatal configuration error blinks green 10 Hz
// RL5: green 1 Hz on soft errors or teach-in
// RL6: green steady when ready and error free
// RL7: red dark, 1 Hz unaddressed, on fatal
// RL8: diagnostic block byte order one to 241
// RL9: extended diagnosis class follows nominal configuration
// RL10: state byte 1 bit 6 parameter rejected
// RL11: master sets bits 5 and 7 itself
// RL12: state byte 1 bit 4 unsupported function
// RL13: state byte 1 bit 3 extended diagnosis present
// RL14: state byte 1 bit 2 configuration rejected
// RL15: state byte 1 bit 1 not ready
// RL16: master sets bit 0 when slave absent
// RL17: master sets byte 2 bit 7 deactivated
// RL18: byte 2 bit 5 SYNC, bit 4 FREEZE
// RL19: byte 2 bit 3 response watchdog armed
// RL20: byte 2 bit 2 always one
// RL21: byte 2 bit 0 needs reparameterization
// RL22: byte 3 bit 7 overflow, rest reserved
// RL23: byte 4 first valid master address
// RL24: bytes 5 and 6 identifier, high first
// RL25: byte 7 extended diagnosis byte count
// RL26: reserved bits zero, blink from divider
`ifndef FDI_CFG_SVH
`define FDI_CFG_SVH

// Register byte addresses.
`define FDI_A_CTRL 8'h00
`define FDI_A_NODE 8'h04
`define FDI_A_EVENT 8'h08
`define FDI_A_CLEAR 8'h0C
`define FDI_A_EXTLEN 8'h10
`define FDI_A_EXTWR 8'h14
`define FDI_A_DIAG0 8'h18
`define FDI_A_DIAG1 8'h1C
`define FDI_A_LAMP 8'h20

// Control register fields.
`define FDI_C_READY 0
`define FDI_C_FATAL_CFG 1
`define FDI_C_SOFT_CFG 2
`define FDI_C_CORRECTED 3
`define FDI_C_TEACH 4
`define FDI_C_ADDRESSED 5
`define FDI_C_CYCLING 6
`define FDI_C_FATAL 7
`define FDI_C_CLASS2 8
`define FDI_C_WD 9
`define FDI_CTRL_W 10
`define FDI_CTRL_RST 10'h000

// Event flag positions.
`define FDI_F_PRM_REJ 0
`define FDI_F_PRM_OK 1
`define FDI_F_UNSUP 2
`define FDI_F_CFG_REJ 3
`define FDI_F_SYNC 4
`define FDI_F_FREEZE 5
`define FDI_F_REPRM 6
`define FDI_F_OVF 7

// Node address window and reset value.
`define FDI_NODE_MIN 7'h03
`define FDI_NODE_MAX 7'h63
`define FDI_NODE_RST 7'h7E

// Diagnostic block layout.
`define FDI_DIAG_LAST 8'hF1
`define FDI_STD_LEN 8'h07
`define FDI_CLASS1_LEN 8'h09
`define FDI_CLASS2_LEN 8'h38
`define FDI_EXT_MAX 234

// Timing.
`define FDI_CLK_KHZ 125000
`define FDI_TICK_MS 50
`define FDI_SLOW_MS 500
`define FDI_FLICK_MS 1000
`define FDI_TICK_CYC (`FDI_TICK_MS * `FDI_CLK_KHZ)
`define FDI_SLOW_TICKS (`FDI_SLOW_MS / `FDI_TICK_MS)
`define FDI_FLICK_TICKS (`FDI_FLICK_MS / `FDI_TICK_MS)

`endif

// ---- common/fdi_pkg.sv ----
// Types for the fieldbus slave diagnostic and indicator block.
// Assumes fdi_cfg.svh supplies the numeric constants.
`default_nettype none
package fdi_pkg;
    // Power-up phase of the lamps.
    typedef enum logic [0:0] {PH_FLICKER, PH_RUN} fdi_phase_t;
    // Lamp drive patterns.
    typedef enum logic [2:0] {LM_OFF, LM_ON, LM_SLOW, LM_FAST, LM_FLICK} fdi_lamp_t;
endpackage
`default_nettype wire

// ---- logic/fdi_indicators.sv ----
// Lamp driver and standard slave diagnostic block with an APB register file.
// Assumes one 125 MHz clock, synchronous reset and an APB master on the same clock.
`include "fdi_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module fdi_indicators #(
    parameter int TICK_CYC = `FDI_TICK_CYC,
    parameter int SLOW_TICKS = `FDI_SLOW_TICKS,
    parameter int FLICK_TICKS = `FDI_FLICK_TICKS,
    parameter int EXT_MAX = `FDI_EXT_MAX,
    parameter logic [15:0] IDENT = 16'h5A5A // Arbitrary value.
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] diag_idx,
    output logic [7:0] diag_byte,
    output logic red_fault_lamp,
    output logic green_state_lamp
);
    typedef struct packed {
        logic [31:0] div;
        logic [7:0] slow_cnt;
        logic [7:0] flick_cnt;
        logic fast_ph;
        logic slow_ph;
        fdi_pkg::fdi_phase_t phase;
        logic [`FDI_CTRL_W-1:0] ctrl;
        logic [6:0] node;
        logic [7:0] flags;
        logic [7:0] maddr;
        logic [7:0] extlen;
        logic [EXT_MAX-1:0][7:0] mem;
        logic [31:0] rdata;
        logic err;
        logic [7:0] dbyte;
        logic red;
        logic green;
    } fdi_state_t;

    fdi_state_t s_r;
    fdi_state_t s_nxt;
    logic setup;
    logic wr;
    logic addr_ok;
    logic node_ok;
    logic [7:0] ext_cap;
    logic [7:0] ext_rep;
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic [7:0] byte3;
    fdi_pkg::fdi_lamp_t green_mode;
    fdi_pkg::fdi_lamp_t red_mode;

    // Bus phase decode; access completes with no wait state.
    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    assign pready = 1'b1;
    assign prdata = s_r.rdata;
    assign pslverr = s_r.err;
    assign diag_byte = s_r.dbyte;
    assign red_fault_lamp = s_r.red;
    assign green_state_lamp = s_r.green;

    // Address decode for known registers.
    always_comb
    begin
        if (paddr == `FDI_A_CTRL || paddr == `FDI_A_NODE || paddr == `FDI_A_EVENT)
        begin
            addr_ok = 1'b1;
        end
        else if (paddr == `FDI_A_CLEAR || paddr == `FDI_A_EXTLEN || paddr == `FDI_A_EXTWR)
        begin
            addr_ok = 1'b1;
        end
        else if (paddr == `FDI_A_DIAG0 || paddr == `FDI_A_DIAG1 || paddr == `FDI_A_LAMP)
        begin
            addr_ok = 1'b1;
        end
        else
        begin
            addr_ok = 1'b0;
        end
    end

    // Station address window and the extended length cap chosen by configuration.
    assign node_ok = (s_r.node >= `FDI_NODE_MIN) && (s_r.node <= `FDI_NODE_MAX); // RL3
    assign ext_cap = s_r.ctrl[`FDI_C_CLASS2] ? `FDI_CLASS2_LEN : `FDI_CLASS1_LEN; // RL9
    assign ext_rep = (s_r.extlen > ext_cap) ? ext_cap : s_r.extlen; // RL25

    // Station state bytes; bits the master owns stay zero here.
    always_comb
    begin
        byte1 = 8'h00; // RL11 RL16
        byte1[6] = s_r.flags[`FDI_F_PRM_REJ]; // RL10
        byte1[4] = s_r.flags[`FDI_F_UNSUP]; // RL12
        byte1[3] = (ext_rep != 8'h00); // RL13
        byte1[2] = s_r.flags[`FDI_F_CFG_REJ]; // RL14
        byte1[1] = !s_r.ctrl[`FDI_C_READY]; // RL15
        byte2 = 8'h00; // RL17 RL26
        byte2[5] = s_r.flags[`FDI_F_SYNC]; // RL18
        byte2[4] = s_r.flags[`FDI_F_FREEZE]; // RL18
        byte2[3] = s_r.ctrl[`FDI_C_WD]; // RL19
        byte2[2] = 1'b1; // RL20
        byte2[0] = s_r.flags[`FDI_F_REPRM]; // RL21
        byte3 = {s_r.flags[`FDI_F_OVF], 7'h00}; // RL22
    end

    // Pattern selection for both lamps in priority order.
    always_comb
    begin
        if (s_r.phase == fdi_pkg::PH_FLICKER)
        begin
            green_mode = fdi_pkg::LM_FLICK; // RL2
            red_mode = fdi_pkg::LM_FLICK; // RL2
        end
        else
        begin
            if (!node_ok)
            begin
                green_mode = fdi_pkg::LM_OFF; // RL3
            end
            else if (s_r.ctrl[`FDI_C_FATAL_CFG])
            begin
                green_mode = fdi_pkg::LM_FAST; // RL4
            end
            else if (s_r.ctrl[`FDI_C_SOFT_CFG] || s_r.ctrl[`FDI_C_CORRECTED] || s_r.ctrl[`FDI_C_TEACH])
            begin
                green_mode = fdi_pkg::LM_SLOW; // RL5
            end
            else if (s_r.ctrl[`FDI_C_READY])
            begin
                green_mode = fdi_pkg::LM_ON; // RL6
            end
            else
            begin
                green_mode = fdi_pkg::LM_OFF;
            end
            if (s_r.ctrl[`FDI_C_FATAL])
            begin
                red_mode = fdi_pkg::LM_ON; // RL7
            end
            else if (!s_r.ctrl[`FDI_C_ADDRESSED])
            begin
                red_mode = fdi_pkg::LM_SLOW; // RL7
            end
            else
            begin
                red_mode = fdi_pkg::LM_OFF; // RL7
            end
        end
    end

    // Turns a pattern into a lamp level.
    function automatic logic lamp_lvl(input fdi_pkg::fdi_lamp_t m, input logic fast, input logic slow);
        case (m)
            fdi_pkg::LM_ON: lamp_lvl = 1'b1;
            fdi_pkg::LM_SLOW: lamp_lvl = slow;
            fdi_pkg::LM_FAST, fdi_pkg::LM_FLICK: lamp_lvl = fast;
            default: lamp_lvl = 1'b0;
        endcase
    endfunction

    // Next state: divider, power-up phase, registers, read data and diagnostic port.
    always_comb
    begin
        s_nxt = s_r;
        // A tick every 50 ms gives 10 Hz; ten ticks give 1 Hz.
        if (s_r.div == 32'(TICK_CYC - 1)) // RL26
        begin
            s_nxt.div = 32'h0000_0000;
            s_nxt.fast_ph = !s_r.fast_ph;
            if (s_r.slow_cnt == 8'(SLOW_TICKS - 1))
            begin
                s_nxt.slow_cnt = 8'h00;
                s_nxt.slow_ph = !s_r.slow_ph;
            end
            else
            begin
                s_nxt.slow_cnt = s_r.slow_cnt + 8'h01;
            end
            if (s_r.phase == fdi_pkg::PH_FLICKER)
            begin
                if (s_r.flick_cnt == 8'(FLICK_TICKS - 1))
                begin
                    s_nxt.phase = fdi_pkg::PH_RUN; // RL2
                end
                else
                begin
                    s_nxt.flick_cnt = s_r.flick_cnt + 8'h01;
                end
            end
        end
        else
        begin
            s_nxt.div = s_r.div + 32'h0000_0001;
        end
        s_nxt.green = lamp_lvl(green_mode, s_r.fast_ph, s_r.slow_ph); // RL1
        s_nxt.red = lamp_lvl(red_mode, s_r.fast_ph, s_r.slow_ph); // RL1
        // Register writes take effect at the access edge.
        if (wr)
        begin
            if (paddr == `FDI_A_CTRL)
            begin
                s_nxt.ctrl = pwdata[`FDI_CTRL_W-1:0];
            end
            else if (paddr == `FDI_A_NODE)
            begin
                s_nxt.node = pwdata[6:0];
            end
            else if (paddr == `FDI_A_CLEAR)
            begin
                s_nxt.flags = s_r.flags & ~pwdata[7:0];
                if (pwdata[`FDI_F_PRM_OK])
                begin
                    s_nxt.maddr = 8'h00;
                end
            end
            else if (paddr == `FDI_A_EVENT)
            begin
                // Setting only ORs ones into the flags; a flag is cleared only by a write to CLEAR.
                s_nxt.flags = s_r.flags | pwdata[7:0];
                if (pwdata[`FDI_F_PRM_OK] && !s_r.flags[`FDI_F_PRM_OK])
                begin
                    s_nxt.maddr = pwdata[15:8]; // RL23
                end
            end
            else if (paddr == `FDI_A_EXTLEN)
            begin
                s_nxt.extlen = pwdata[7:0];
                if (pwdata[7:0] > ext_cap)
                begin
                    s_nxt.flags[`FDI_F_OVF] = 1'b1; // RL22
                end
            end
            else if (paddr == `FDI_A_EXTWR)
            begin
                if (32'(pwdata[15:8]) < EXT_MAX)
                begin
                    s_nxt.mem[pwdata[15:8]] = pwdata[7:0];
                end
            end
        end
        // Read data and error are captured in the setup cycle.
        if (setup)
        begin
            s_nxt.err = !addr_ok;
            if (paddr == `FDI_A_CTRL)
            begin
                s_nxt.rdata = 32'(s_r.ctrl);
            end
            else if (paddr == `FDI_A_NODE)
            begin
                s_nxt.rdata = {24'h00_0000, node_ok, s_r.node};
            end
            else if (paddr == `FDI_A_EVENT)
            begin
                s_nxt.rdata = {24'h00_0000, s_r.flags};
            end
            else if (paddr == `FDI_A_EXTLEN)
            begin
                s_nxt.rdata = {16'h0000, ext_rep, s_r.extlen};
            end
            else if (paddr == `FDI_A_DIAG0)
            begin
                s_nxt.rdata = {s_r.maddr, byte3, byte2, byte1}; // RL8
            end
            else if (paddr == `FDI_A_DIAG1)
            begin
                s_nxt.rdata = {8'h00, ext_rep, IDENT[7:0], IDENT[15:8]}; // RL24
            end
            else if (paddr == `FDI_A_LAMP)
            begin
                s_nxt.rdata = {29'h0000_0000, s_r.phase == fdi_pkg::PH_RUN, s_r.green, s_r.red};
            end
            else
            begin
                s_nxt.rdata = 32'h0000_0000;
            end
        end
        // Diagnostic block, byte 1 first.
        if (diag_idx == 8'h01)
        begin
            s_nxt.dbyte = byte1; // RL8
        end
        else if (diag_idx == 8'h02)
        begin
            s_nxt.dbyte = byte2;
        end
        else if (diag_idx == 8'h03)
        begin
            s_nxt.dbyte = byte3;
        end
        else if (diag_idx == 8'h04)
        begin
            s_nxt.dbyte = s_r.maddr; // RL23
        end
        else if (diag_idx == 8'h05)
        begin
            s_nxt.dbyte = IDENT[15:8]; // RL24
        end
        else if (diag_idx == 8'h06)
        begin
            s_nxt.dbyte = IDENT[7:0]; // RL24
        end
        else if (diag_idx == `FDI_STD_LEN)
        begin
            s_nxt.dbyte = ext_rep; // RL25
        end
        else if (diag_idx > `FDI_STD_LEN && diag_idx <= `FDI_DIAG_LAST
                 && diag_idx <= `FDI_STD_LEN + ext_rep && 32'(diag_idx) - 32'd8 < EXT_MAX)
        begin
            s_nxt.dbyte = s_r.mem[diag_idx - 8'h08]; // RL9
        end
        else
        begin
            s_nxt.dbyte = 8'h00;
        end
    end

    // State register.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s_r <= '0;
            s_r.phase <= fdi_pkg::PH_FLICKER;
            s_r.ctrl <= `FDI_CTRL_RST;
            s_r.node <= `FDI_NODE_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_run_addr_bad;
        s_r.phase == fdi_pkg::PH_RUN && !node_ok;
    endsequence
    sequence s_ready_clean;
        s_r.phase == fdi_pkg::PH_RUN && node_ok && s_r.ctrl[`FDI_C_READY] && !s_r.ctrl[`FDI_C_FATAL_CFG]
        && !s_r.ctrl[`FDI_C_SOFT_CFG] && !s_r.ctrl[`FDI_C_CORRECTED] && !s_r.ctrl[`FDI_C_TEACH];
    endsequence
    sequence s_prm_rej_write;
        psel && penable && pwrite && paddr == `FDI_A_EVENT && pwdata[`FDI_F_PRM_REJ];
    endsequence

    property p_flicker_both;
        s_r.phase == fdi_pkg::PH_FLICKER |=> red_fault_lamp == green_state_lamp;
    endproperty
    a_flicker_both: assert property (p_flicker_both) else $error("Lamps differ during flicker."); // RL2
    property p_bad_addr_dark;
        s_run_addr_bad ##1 s_run_addr_bad |=> !green_state_lamp;
    endproperty
    a_bad_addr_dark: assert property (p_bad_addr_dark) else $error("Green lit with bad address."); // RL3
    property p_fast_green;
        s_r.phase == fdi_pkg::PH_RUN && node_ok && s_r.ctrl[`FDI_C_FATAL_CFG] |=> green_state_lamp == $past(s_r.fast_ph);
    endproperty
    a_fast_green: assert property (p_fast_green) else $error("Green not on fast blink."); // RL4
    property p_ready_on;
        s_ready_clean |=> green_state_lamp;
    endproperty
    a_ready_on: assert property (p_ready_on) else $error("Green dark while ready."); // RL6
    property p_red_fatal;
        (s_r.phase == fdi_pkg::PH_RUN && s_r.ctrl[`FDI_C_FATAL]) [*2] |=> red_fault_lamp;
    endproperty
    a_red_fatal: assert property (p_red_fatal) else $error("Red dark on fatal fault."); // RL7
    property p_prm_rej;
        s_prm_rej_write |=> ##1 diag_idx == 8'h01 |=> diag_byte[6];
    endproperty
    a_prm_rej: assert property (p_prm_rej) else $error("Parameter fault bit missing."); // RL10
    property p_slave_bit;
        diag_idx == 8'h02 |=> diag_byte[2] && !diag_byte[6] && !diag_byte[7];
    endproperty
    a_slave_bit: assert property (p_slave_bit) else $error("Byte 2 slave bit wrong."); // RL20
    property p_ident_hi;
        diag_idx == 8'h05 ##1 diag_idx == 8'h06 |-> diag_byte == IDENT[15:8] ##1 diag_byte == IDENT[7:0];
    endproperty
    a_ident_hi: assert property (p_ident_hi) else $error("Identifier order wrong."); // RL24
    property p_ext_flag;
        diag_idx == 8'h01 |=> diag_byte[3] == ($past(ext_rep) != 8'h00);
    endproperty
    a_ext_flag: assert property (p_ext_flag) else $error("Extended flag wrong."); // RL13
endmodule
`default_nettype wire

// ---- dv/fdi_master_model.sv ----
// Fieldbus master model that polls the slave diagnostic bytes one at a time.
// Assumes diag_byte follows diag_idx by one clock edge, all on clk.
`timescale 1ns/10ps
`default_nettype none
module fdi_master_model (
    input wire logic clk,
    output logic [7:0] diag_idx,
    input wire logic [7:0] diag_byte
);
    // The index rests at zero between polls.
    initial diag_idx = 8'h00;

    // Polls one byte, holding the index for extra cycles when slow is non-zero.
    // The raw copy handed back leaves the master-owned state bits clear for the caller.
    task automatic poll(input logic [7:0] idx, input int slow, output logic [7:0] b);
        @(posedge clk);
        diag_idx <= idx;
        repeat (1 + slow) @(posedge clk);
        #1;
        b = diag_byte;
        @(posedge clk);
        diag_idx <= 8'h00;
    endtask

    // Polls two neighbouring bytes on consecutive cycles, as a burst read does.
    task automatic pair(input logic [7:0] idx, output logic [7:0] b0, output logic [7:0] b1);
        @(posedge clk);
        diag_idx <= idx;
        @(posedge clk);
        diag_idx <= idx + 8'h01;
        #1;
        b0 = diag_byte;
        @(posedge clk);
        diag_idx <= 8'h00;
        #1;
        b1 = diag_byte;
    endtask
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the lamp driver and standard diagnostic block.
// Assumes the master model in this folder and shortened lamp timing parameters.
`include "fdi_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam logic [15:0] IDENT = 16'h3C96; // Arbitrary value.
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic err;
    logic red;
    logic green;
    logic [7:0] diag_idx;
    logic [7:0] diag_byte;
    logic [7:0] b;
    int bad_count = 0;
    int total_checks = 0;

    // Free-running 125 MHz clock.
    always #4 clk = ~clk;

    fdi_indicators #(.TICK_CYC(4), .SLOW_TICKS(2), .FLICK_TICKS(3), .EXT_MAX(`FDI_EXT_MAX), .IDENT(IDENT)) dut (
        .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .diag_idx(diag_idx),
        .diag_byte(diag_byte), .red_fault_lamp(red), .green_state_lamp(green));

    fdi_master_model m (.clk(clk), .diag_idx(diag_idx), .diag_byte(diag_byte));

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
        begin
            $display("Run complete: PASS");
        end
        else
        begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Compares a seen value with the expected one and counts the outcome.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; read data and error are taken at the edge that sees pready.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        if (n == 20)
        begin
            chk(32'h0, 32'h1);
            print_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Classifies a lamp from its toggle count: 0 or 1 steady, 2 slow, 3 fast, 7 wrong.
    function automatic logic [2:0] mode(input int t, input logic lv);
        if (t == 0)
            return {2'b00, lv};
        if (t >= 6 && t <= 10)
            return 3'h2;
        if (t >= 14 && t <= 18)
            return 3'h3;
        return 3'h7;
    endfunction

    // Lets the lamps settle, then counts toggles over 64 cycles.
    task automatic lamps(input logic [2:0] ge, input logic [2:0] re);
        int tg;
        int tr;
        logic pg;
        logic pr;
        tg = 0;
        tr = 0;
        repeat (24) @(posedge clk);
        #1;
        pg = green;
        pr = red;
        repeat (64)
        begin
            @(posedge clk);
            #1;
            tg += int'(green !== pg);
            tr += int'(red !== pr);
            pg = green;
            pr = red;
        end
        chk({29'h0, mode(tg, green)}, {29'h0, ge});
        chk({29'h0, mode(tr, red)}, {29'h0, re});
    endtask

    // Both lamps flicker together after reset, then the flicker phase ends.
    task automatic t_reset();
        int tg;
        int diff;
        logic pg;
        tg = 0;
        diff = 0;
        pg = green;
        chk({30'h0, red, green}, 32'h0);
        repeat (10)
        begin
            @(posedge clk);
            #1;
            tg += int'(green !== pg);
            diff += int'(green !== red);
            pg = green;
        end
        chk(32'(tg >= 1 && diff == 0), 32'h1);
        apb(1'b0, `FDI_A_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `FDI_A_NODE, 32'h0);
        chk(rd, 32'h7E);
        rd = 32'h0;
        for (int i = 0; i < 10 && rd[2] !== 1'b1; i++)
            apb(1'b0, `FDI_A_LAMP, 32'h0);
        chk({31'h0, rd[2]}, 32'h1);
        $display("t_reset done");
    endtask

    // Lamp patterns for each node address and condition; fields: node, ctrl, green, red.
    task automatic t_lamps();
        logic [27:0] tab[10] = '{
            28'h7E00002, 28'h3206110,
            28'h0206100, 28'h6406100, 28'h0306110,
            28'h6300332, 28'h3206520, 28'h3206920, 28'h3207120,
            28'h320E111};
        foreach (tab[i])
        begin
            apb(1'b1, `FDI_A_NODE, {25'h0, tab[i][26:20]});
            apb(1'b1, `FDI_A_CTRL, {20'h0, tab[i][19:8]});
            apb(1'b0, `FDI_A_NODE, 32'h0);
            chk(rd, {24'h0, tab[i][27:20] >= 8'h03 && tab[i][27:20] <= 8'h63, tab[i][26:20]});
            lamps(tab[i][6:4], tab[i][2:0]);
        end
        $display("t_lamps done");
    endtask

    // State bytes, master address, identifier, lengths and extended bytes.
    task automatic t_diag();
        logic [7:0] ix[12] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h10, 8'h11, 8'h00, 8'hF2};
        logic [7:0] ex[12] = '{8'h5E, 8'h3D, 8'h80, 8'h22, IDENT[15:8], IDENT[7:0], 8'h09, 8'hA5, 8'h3C,
            8'h00, 8'h00, 8'h00};
        apb(1'b1, `FDI_A_CTRL, 32'h200);
        apb(1'b1, `FDI_A_CLEAR, 32'hFF);
        apb(1'b1, `FDI_A_EXTLEN, 32'h0);
        apb(1'b1, `FDI_A_EVENT, 32'h227F);
        m.poll(8'h01, 0, b);
        chk({24'h0, b}, 32'h56);
        apb(1'b1, `FDI_A_EVENT, 32'h3302);
        apb(1'b0, `FDI_A_DIAG0, 32'h0);
        chk(rd, 32'h22003D56);
        apb(1'b0, `FDI_A_DIAG1, 32'h0);
        chk(rd, {16'h0, IDENT[7:0], IDENT[15:8]});
        apb(1'b1, `FDI_A_EXTLEN, 32'h14);
        apb(1'b0, `FDI_A_EXTLEN, 32'h0);
        chk(rd, 32'h0914);
        apb(1'b0, `FDI_A_DIAG0, 32'h0);
        chk(rd, 32'h22803D5E);
        apb(1'b1, `FDI_A_EXTWR, 32'h00A5);
        apb(1'b1, `FDI_A_EXTWR, 32'h083C);
        foreach (ix[i])
        begin
            m.poll(ix[i], i % 3, b);
            chk({24'h0, b}, {24'h0, ex[i]});
        end
        m.pair(8'h05, b, rd[7:0]);
        chk({24'h0, b}, {24'h0, IDENT[15:8]});
        chk({24'h0, rd[7:0]}, {24'h0, IDENT[7:0]});
        apb(1'b1, `FDI_A_CTRL, 32'h301);
        apb(1'b1, `FDI_A_EXTLEN, 32'h14);
        apb(1'b0, `FDI_A_EXTLEN, 32'h0);
        chk(rd, 32'h1414);
        apb(1'b1, `FDI_A_CLEAR, 32'hFF);
        apb(1'b0, `FDI_A_DIAG0, 32'h0);
        chk(rd, 32'h00000C08);
        apb(1'b1, `FDI_A_EVENT, 32'h4402);
        apb(1'b0, `FDI_A_DIAG0, 32'h0);
        chk(rd, 32'h44000C08);
        $display("t_diag done");
    endtask

    // Unmapped and read-only places refuse writes as the map says.
    task automatic t_refuse();
        apb(1'b1, 8'h40, 32'h1);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, `FDI_A_DIAG0, 32'hFFFFFFFF);
        chk({31'h0, err}, 32'h0);
        apb(1'b0, `FDI_A_DIAG0, 32'h0);
        chk(rd, 32'h44000C08);
        apb(1'b0, `FDI_A_CLEAR, 32'h0);
        chk(rd, 32'h0);
        $display("t_refuse done");
    endtask

    // Main sequence: reset for two cycles, then every scenario in turn.
    initial
    begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_lamps();
        t_diag();
        t_refuse();
        print_verdict();
    end
endmodule
`default_nettype wire
